// ===== shared/pimb_regs.vh
// register offsets, field positions and reset values of the interrupt mask bank
// assumes an 8-bit register access port with 8-bit addresses
`ifndef PIMB_REGS_VH
`define PIMB_REGS_VH

// ----------------------------------------------------------------------------
// offsets
// ----------------------------------------------------------------------------
`define PIMB_ADDR_TOP_MASK_ONE  8'h20
`define PIMB_ADDR_TOP_MASK_TWO  8'h21
`define PIMB_ADDR_CONV_MASK     8'h22
`define PIMB_ADDR_TOP_STATUS    8'h28
`define PIMB_ADDR_CONV_STATUS   8'h29
`define PIMB_ADDR_TOP_FLAGS     8'h2a
`define PIMB_ADDR_CONV_FLAGS    8'h2b

// ----------------------------------------------------------------------------
// top mask one fields
// ----------------------------------------------------------------------------
`define PIMB_TM1_SYNC_CLK       4
`define PIMB_TM1_THERMAL        2
`define PIMB_TM1_MEAS           0
`define PIMB_TM1_WMASK          8'hff
`define PIMB_TM1_RESET          8'h15

// ----------------------------------------------------------------------------
// top mask two fields
// ----------------------------------------------------------------------------
`define PIMB_TM2_REG_RESET      0
`define PIMB_TM2_RESET          8'h00

// ----------------------------------------------------------------------------
// converter mask fields
// ----------------------------------------------------------------------------
`define PIMB_CM_C1_PG_FALL      7
`define PIMB_CM_C1_PG_RISE      6
`define PIMB_CM_C1_ILIM         4
`define PIMB_CM_C0_PG_FALL      3
`define PIMB_CM_C0_PG_RISE      2
`define PIMB_CM_C0_ILIM         0
`define PIMB_CM_WMASK           8'hdd
`define PIMB_CM_RESET           8'hdd

// ----------------------------------------------------------------------------
// converter status fields (power good reads 1 when invalid)
// ----------------------------------------------------------------------------
`define PIMB_CS_C1_PG           6
`define PIMB_CS_C1_ILIM         4
`define PIMB_CS_C0_PG           2
`define PIMB_CS_C0_ILIM         0

`endif

// ===== design/pimb_sync.v
// two-flop synchroniser for a vector of asynchronous levels
// assumes the inputs are quasi-static levels from analog or pin logic
module pimb_sync #(
	parameter WIDTH = 8
) (
	ref_clk,
	sys_rst,
	asyncIn,
	syncOut
);
	input  wire             ref_clk;
	input  wire             sys_rst;
	input  wire [WIDTH-1:0] asyncIn;
	output wire [WIDTH-1:0] syncOut;

	reg [WIDTH-1:0] stageOne_ff;
	reg [WIDTH-1:0] stageTwo_ff;

	always @(posedge ref_clk)
	begin
		if (sys_rst)
		begin
			stageOne_ff <= {WIDTH{1'b0}};
			stageTwo_ff <= {WIDTH{1'b0}};
		end
		else
		begin
			stageOne_ff <= asyncIn;
			stageTwo_ff <= stageOne_ff;
		end
	end

	assign syncOut = stageTwo_ff;
endmodule

// ===== design/pimb_mask_mem.v
// three-word mask store with registered read data
// assumes one write and one read port, both on ref_clk
`include "pimb_regs.vh"
module pimb_mask_mem (
	ref_clk,
	sys_rst,
	otpRegResetMask,
	wrEn,
	wrIdx,
	wrData,
	rdIdx,
	rdData,
	maskOne,
	maskTwo,
	maskConv
);
	input  wire       ref_clk;
	input  wire       sys_rst;
	input  wire       otpRegResetMask;
	input  wire       wrEn;
	input  wire [1:0] wrIdx;
	input  wire [7:0] wrData;
	input  wire [1:0] rdIdx;
	output reg  [7:0] rdData;
	output wire [7:0] maskOne;
	output wire [7:0] maskTwo;
	output wire [7:0] maskConv;

	reg [7:0] word_ff [0:2];

	// ------------------------------------------------------------------------
	// storage
	// ------------------------------------------------------------------------
	always @(posedge ref_clk)
	begin
		if (sys_rst)
		begin
			word_ff[0] <= `PIMB_TM1_RESET;
			word_ff[1] <= `PIMB_TM2_RESET;
			word_ff[2] <= `PIMB_CM_RESET;
		end
		else
		begin
			// reload every cycle: a bus write to this bit cannot stick
			word_ff[1][`PIMB_TM2_REG_RESET] <= otpRegResetMask;
			if (wrEn && wrIdx == 2'd0)
				word_ff[0] <= wrData & `PIMB_TM1_WMASK;
			if (wrEn && wrIdx == 2'd1)
				word_ff[1][7:1] <= wrData[7:1];
			if (wrEn && wrIdx == 2'd2)
				word_ff[2] <= wrData & `PIMB_CM_WMASK;
		end
	end

	always @(posedge ref_clk)
	begin
		if (sys_rst)
			rdData <= 8'h00;
		else if (rdIdx == 2'd3)
			rdData <= 8'h00;
		else
			rdData <= word_ff[rdIdx];
	end

	assign maskOne  = word_ff[0];
	assign maskTwo  = word_ff[1];
	assign maskConv = word_ff[2];
endmodule

// ===== design/pimb_top.v
// interrupt mask bank: per-source gating of event flags onto one interrupt line
// assumes the serial port decoder hands over byte writes/reads on ref_clk,
// and raw conditions arrive asynchronously from analog comparators
//
// Contract
// - sync-clock mask bit4 zero lets interrupt
// - sync-clock status stays raw regardless mask
// - thermal mask bit2 zero lets interrupt
// - thermal status stays raw regardless mask
// - measurement mask bit0 zero lets interrupt
// - second top mask bit0 gates reg-reset
// - bit7 gates converter1 invalid-going power good
// - bit6 gates converter1 valid-going power good
// - bit4 gates converter1 current limit
// - bit3 gates converter0 invalid-going power good
// - bit2 gates converter0 valid-going power good
// - bit0 gates converter0 current limit
// - masks never alter converter raw status
// - power good raw: 0 valid, 1 invalid
`include "pimb_regs.vh"
module pimb_top (
	ref_clk,
	sys_rst,
	regWrEn,
	regRdEn,
	regAddr,
	regWrData,
	regRdData,
	regRdValid,
	syncClkDetect,
	thermalWarning,
	measReadyPulse,
	regResetPulse,
	otpRegResetMask,
	conv1PgInvalid,
	conv1CurrentLimit,
	conv0PgInvalid,
	conv0CurrentLimit,
	irqOut
);
	input  wire       ref_clk;
	input  wire       sys_rst;
	input  wire       regWrEn;
	input  wire       regRdEn;
	input  wire [7:0] regAddr;
	input  wire [7:0] regWrData;
	output reg  [7:0] regRdData;
	output reg        regRdValid;
	input  wire       syncClkDetect;
	input  wire       thermalWarning;
	input  wire       measReadyPulse;
	input  wire       regResetPulse;
	input  wire       otpRegResetMask;
	input  wire       conv1PgInvalid;
	input  wire       conv1CurrentLimit;
	input  wire       conv0PgInvalid;
	input  wire       conv0CurrentLimit;
	output reg        irqOut;

	// ------------------------------------------------------------------------
	// input synchronisation
	// ------------------------------------------------------------------------
	wire [6:0] rawSync;
	pimb_sync #(.WIDTH(7)) uSync (
		.ref_clk (ref_clk),
		.sys_rst (sys_rst),
		.asyncIn ({syncClkDetect, thermalWarning, conv1PgInvalid, conv1CurrentLimit,
			conv0PgInvalid, conv0CurrentLimit, otpRegResetMask}),
		.syncOut (rawSync)
	);
	wire syncClkRaw       = rawSync[6];
	wire thermal_warning_raw = rawSync[5];
	wire conv1_pg_raw     = rawSync[4];
	wire conv1_current_limit_raw = rawSync[3];
	wire conv0_pg_raw     = rawSync[2];
	wire conv0_current_limit_raw = rawSync[1];
	wire otpMaskSync      = rawSync[0];

	// ------------------------------------------------------------------------
	// address decode
	// ------------------------------------------------------------------------
	function [1:0] maskIdx;
		input [7:0] addr;
		begin
			case (addr)
				`PIMB_ADDR_TOP_MASK_ONE: maskIdx = 2'd0;
				`PIMB_ADDR_TOP_MASK_TWO: maskIdx = 2'd1;
				`PIMB_ADDR_CONV_MASK:    maskIdx = 2'd2;
				default:                 maskIdx = 2'd3;
			endcase
		end
	endfunction

	wire [7:0] maskOne;
	wire [7:0] maskTwo;
	wire [7:0] maskConv;
	wire [7:0] memRdData;
	wire [1:0] wrIdx = maskIdx(regAddr);

	pimb_mask_mem uMem (
		.ref_clk         (ref_clk),
		.sys_rst         (sys_rst),
		.otpRegResetMask (otpMaskSync),
		.wrEn            (regWrEn && wrIdx != 2'd3),
		.wrIdx           (wrIdx),
		.wrData          (regWrData),
		.rdIdx           (maskIdx(regAddr)),
		.rdData          (memRdData),
		.maskOne         (maskOne),
		.maskTwo         (maskTwo),
		.maskConv        (maskConv)
	);

	// ------------------------------------------------------------------------
	// edge detection of raw conditions
	// ------------------------------------------------------------------------
	// the two pulse inputs get their own synchronisers: only their edges count,
	// so a pulse shorter than one cycle may be lost
	reg [5:0] rawPrev_ff;
	reg       measPrev_ff;
	reg       regResetPrev_ff;
	reg [1:0] measSync_ff;
	reg [1:0] regResetSync_ff;

	always @(posedge ref_clk)
	begin
		if (sys_rst)
		begin
			rawPrev_ff      <= 6'h00;
			measSync_ff     <= 2'h0;
			regResetSync_ff <= 2'h0;
			measPrev_ff     <= 1'b0;
			regResetPrev_ff <= 1'b0;
		end
		else
		begin
			rawPrev_ff      <= rawSync[6:1];
			measSync_ff     <= {measSync_ff[0], measReadyPulse};
			regResetSync_ff <= {regResetSync_ff[0], regResetPulse};
			measPrev_ff     <= measSync_ff[1];
			regResetPrev_ff <= regResetSync_ff[1];
		end
	end

	wire syncClkEvt  = syncClkRaw & ~rawPrev_ff[5];
	wire thermalEvt  = thermal_warning_raw & ~rawPrev_ff[4];
	wire measEvt     = measSync_ff[1] & ~measPrev_ff;
	wire regResetEvt = regResetSync_ff[1] & ~regResetPrev_ff;
	// power good raw is 1 when invalid: rising raw is invalid-going
	wire c1PgFallEvt = conv1_pg_raw & ~rawPrev_ff[3];
	wire c1PgRiseEvt = ~conv1_pg_raw & rawPrev_ff[3];
	wire c1IlimEvt   = conv1_current_limit_raw & ~rawPrev_ff[2];
	wire c0PgFallEvt = conv0_pg_raw & ~rawPrev_ff[1];
	wire c0PgRiseEvt = ~conv0_pg_raw & rawPrev_ff[1];
	wire c0IlimEvt   = conv0_current_limit_raw & ~rawPrev_ff[0];

	// ------------------------------------------------------------------------
	// gated flag setting
	// ------------------------------------------------------------------------
	wire setSyncClk  = syncClkEvt & ~maskOne[`PIMB_TM1_SYNC_CLK];
	wire setThermal  = thermalEvt & ~maskOne[`PIMB_TM1_THERMAL];
	wire setMeas     = measEvt & ~maskOne[`PIMB_TM1_MEAS];
	wire setRegReset = regResetEvt & ~maskTwo[`PIMB_TM2_REG_RESET];
	wire setC1Pg     = (c1PgFallEvt & ~maskConv[`PIMB_CM_C1_PG_FALL])
		| (c1PgRiseEvt & ~maskConv[`PIMB_CM_C1_PG_RISE]);
	wire setC1Ilim   = c1IlimEvt & ~maskConv[`PIMB_CM_C1_ILIM];
	wire setC0Pg     = (c0PgFallEvt & ~maskConv[`PIMB_CM_C0_PG_FALL])
		| (c0PgRiseEvt & ~maskConv[`PIMB_CM_C0_PG_RISE]);
	wire setC0Ilim   = c0IlimEvt & ~maskConv[`PIMB_CM_C0_ILIM];

	// flags are write-one-to-clear; a set in the clearing cycle wins
	// irqOut is built from the next flag value, so it rises with the flag
	reg  [7:0] topFlags_ff;
	reg  [7:0] convFlags_ff;
	wire [7:0] topSet  = {3'h0, setSyncClk, 1'b0, setThermal, setRegReset, setMeas};
	wire [7:0] convSet = {1'b0, setC1Pg, 1'b0, setC1Ilim, 1'b0, setC0Pg, 1'b0, setC0Ilim};
	wire [7:0] topClr  = (regWrEn && regAddr == `PIMB_ADDR_TOP_FLAGS) ? regWrData : 8'h00;
	wire [7:0] convClr = (regWrEn && regAddr == `PIMB_ADDR_CONV_FLAGS) ? regWrData : 8'h00;

	always @(posedge ref_clk)
	begin
		if (sys_rst)
		begin
			topFlags_ff  <= 8'h00;
			convFlags_ff <= 8'h00;
			irqOut       <= 1'b0;
		end
		else
		begin
			topFlags_ff  <= (topFlags_ff & ~topClr) | topSet;
			convFlags_ff <= (convFlags_ff & ~convClr) | convSet;
			irqOut       <= |(((topFlags_ff & ~topClr) | topSet)
				| ((convFlags_ff & ~convClr) | convSet));
		end
	end

	// ------------------------------------------------------------------------
	// read path: status shows raw conditions, never masked
	// ------------------------------------------------------------------------
	wire [7:0] topStatus  = {3'h0, syncClkRaw, 1'b0, thermal_warning_raw, 2'h0};
	wire [7:0] convStatus = {1'b0, conv1_pg_raw, 1'b0, conv1_current_limit_raw,
		1'b0, conv0_pg_raw, 1'b0, conv0_current_limit_raw};
	reg  [7:0] rdAddr_ff;
	reg        rdPend_ff;
	reg  [7:0] nxt_rdData;

	always @(posedge ref_clk)
	begin
		if (sys_rst)
		begin
			rdAddr_ff <= 8'h00;
			rdPend_ff <= 1'b0;
		end
		else
		begin
			rdAddr_ff <= regAddr;
			rdPend_ff <= regRdEn;
		end
	end

	// mask words come out of the memory one cycle late, so the answer
	// is muxed one cycle after the request, registered a cycle later
	always @*
	begin
		case (rdAddr_ff)
			`PIMB_ADDR_TOP_STATUS:  nxt_rdData = topStatus;
			`PIMB_ADDR_CONV_STATUS: nxt_rdData = convStatus;
			`PIMB_ADDR_TOP_FLAGS:   nxt_rdData = topFlags_ff;
			`PIMB_ADDR_CONV_FLAGS:  nxt_rdData = convFlags_ff;
			default:                nxt_rdData = memRdData;
		endcase
	end

	always @(posedge ref_clk)
	begin
		if (sys_rst)
		begin
			regRdData  <= 8'h00;
			regRdValid <= 1'b0;
		end
		else
		begin
			regRdValid <= rdPend_ff;
			if (rdPend_ff)
				regRdData <= nxt_rdData;
		end
	end
endmodule

// ===== dv/pimb_props.sv
// checker: mask gating, raw status reads and the interrupt line of pimb_top
// assumes it is bound to pimb_top and sees only its ports
module pimb_props (
	input logic       ref_clk,
	input logic       sys_rst,
	input logic       regWrEn,
	input logic       regRdEn,
	input logic [7:0] regAddr,
	input logic [7:0] regWrData,
	input logic       regRdValid,
	input logic [7:0] regRdData,
	input logic       syncClkDetect,
	input logic       thermalWarning,
	input logic       regResetPulse,
	input logic       otpRegResetMask,
	input logic       conv1PgInvalid,
	input logic       conv1CurrentLimit,
	input logic       conv0PgInvalid,
	input logic       conv0CurrentLimit,
	input logic       irqOut
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (sys_rst);
	logic [7:0] oneMask_ff;
	logic [7:0] convMask_ff;
	logic       allMasked;
	// ----------------------------------------------------------------
	// shadow masks, rebuilt from the writes seen at the port
	// ----------------------------------------------------------------
	always @(posedge ref_clk)
	begin
		if (sys_rst)
		begin
			oneMask_ff  <= 8'h15;
			convMask_ff <= 8'hdd;
		end
		else if (regWrEn && regAddr == 8'h20)
			oneMask_ff <= regWrData;
		else if (regWrEn && regAddr == 8'h22)
			convMask_ff <= regWrData;
	end
	assign allMasked = (oneMask_ff & 8'h15) == 8'h15 && (convMask_ff & 8'hdd) == 8'hdd && otpRegResetMask;
	// ----------------------------------------------------------------
	// properties
	// ----------------------------------------------------------------
	property p_syncIrq; $rose(syncClkDetect) && !oneMask_ff[4] |-> ##[2:6] irqOut; endproperty
	a_syncIrq: assert property (p_syncIrq) else $error("sync clock irq missing");
	property p_thermIrq; $rose(thermalWarning) && !oneMask_ff[2] |-> ##[2:6] irqOut; endproperty
	a_thermIrq: assert property (p_thermIrq) else $error("thermal irq missing");
	property p_rstIrq; $rose(regResetPulse) && !otpRegResetMask |-> ##[2:6] irqOut; endproperty
	a_rstIrq: assert property (p_rstIrq) else $error("reg reset irq missing");
	property p_c1Fall; $rose(conv1PgInvalid) && !convMask_ff[7] |-> ##[2:6] irqOut; endproperty
	a_c1Fall: assert property (p_c1Fall) else $error("conv1 invalid irq missing");
	property p_c1Rise; $fell(conv1PgInvalid) && !convMask_ff[6] |-> ##[2:6] irqOut; endproperty
	a_c1Rise: assert property (p_c1Rise) else $error("conv1 valid irq missing");
	property p_c0Ilim; $rose(conv0CurrentLimit) && !convMask_ff[0] |-> ##[2:6] irqOut; endproperty
	a_c0Ilim: assert property (p_c0Ilim) else $error("conv0 limit irq missing");
	// a flag set just before the masks closed is allowed to show, hence the run-in
	property p_masked; allMasked[*6] ##0 !irqOut |=> !irqOut; endproperty
	a_masked: assert property (p_masked) else $error("masked event raised irq");
	property p_topRaw;
		$stable({syncClkDetect, thermalWarning})[*5] ##0 (regRdEn && regAddr == 8'h28) |->
			##2 regRdData[4] == $past(syncClkDetect, 2) && regRdData[2] == $past(thermalWarning, 2);
	endproperty
	a_topRaw: assert property (p_topRaw) else $error("top status not raw");
	property p_convRaw;
		$stable({conv1PgInvalid, conv0PgInvalid})[*5] ##0 (regRdEn && regAddr == 8'h29) |->
			##2 regRdData[6] == $past(conv1PgInvalid, 2) && regRdData[2] == $past(conv0PgInvalid, 2);
	endproperty
	a_convRaw: assert property (p_convRaw) else $error("converter status not raw");
	c_irqRise: cover property ($rose(irqOut));
	c_irqFall: cover property ($fell(irqOut));
	c_readData: cover property (regRdValid && regRdData != 8'h00);
endmodule

bind pimb_top pimb_props u_props (
	.ref_clk, .sys_rst, .regWrEn, .regRdEn, .regAddr, .regWrData, .regRdValid, .regRdData,
	.syncClkDetect, .thermalWarning, .regResetPulse, .otpRegResetMask, .conv1PgInvalid,
	.conv1CurrentLimit, .conv0PgInvalid, .conv0CurrentLimit, .irqOut
);

// ===== dv/pimb_host.sv
// host model: single-byte register transfers on the strobe port
// assumes every strobe is taken at the next rising edge of ref_clk
module pimb_host (
	input  logic       ref_clk,
	output logic       regWrEn,
	output logic       regRdEn,
	output logic [7:0] regAddr,
	output logic [7:0] regWrData
);
	timeunit 1ns;
	timeprecision 1ps;
	initial
	begin
		regWrEn   = 1'b0;
		regRdEn   = 1'b0;
		regAddr   = 8'h00;
		regWrData = 8'h00;
	end
	// address and data are inverted once released so stale values never look valid
	task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		#1;
		regWrEn   = w;
		regRdEn   = !w;
		regAddr   = a;
		regWrData = d;
		@(posedge ref_clk);
		#1;
		regWrEn   = 1'b0;
		regRdEn   = 1'b0;
		regAddr   = ~a;
		regWrData = ~d;
	endtask
endmodule

// ===== dv/testbench.sv
// self-checking bench for the interrupt mask bank
// assumes pimb_top, pimb_host and the bound checker, one 100 MHz clock
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic        ref_clk = 1'b0;
	logic        sys_rst = 1'b1;
	logic        otpRegResetMask = 1'b1;
	logic [7:0]  lv = 8'h00;
	logic        regWrEn, regRdEn, regRdValid, irqOut;
	logic [7:0]  regAddr, regWrData, regRdData, d, sel;
	logic [15:0] q;
	logic [15:0] expQ[$];
	int          failCount = 0;
	int          cmpCount = 0;
	int          seed = 27160;
	int          inIdx[10] = '{0, 1, 2, 3, 4, 4, 5, 6, 6, 7};
	int          mBit[10] = '{4, 2, 0, 0, 7, 6, 4, 3, 2, 0};
	int          fBit[10] = '{4, 2, 0, 1, 6, 6, 4, 2, 2, 0};
	always #5 ref_clk = ~ref_clk;
	pimb_host host (.ref_clk, .regWrEn, .regRdEn, .regAddr, .regWrData);
	pimb_top dut (
		.ref_clk, .sys_rst, .regWrEn, .regRdEn, .regAddr, .regWrData, .regRdData, .regRdValid,
		.syncClkDetect(lv[0]), .thermalWarning(lv[1]), .measReadyPulse(lv[2]), .regResetPulse(lv[3]),
		.otpRegResetMask, .conv1PgInvalid(lv[4]), .conv1CurrentLimit(lv[5]),
		.conv0PgInvalid(lv[6]), .conv0CurrentLimit(lv[7]), .irqOut
	);
	// ----------------------------------------------------------------
	// checking and closing
	// ----------------------------------------------------------------
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		cmpCount++;
		if (seen !== exp)
		begin
			failCount++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
		expQ.push_back({m, e});
		host.xfer(1'b0, a, 8'h00);
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask
	task automatic finalReport;
		$display("compares %0d mismatches %0d", cmpCount, failCount);
		if (failCount == 0 && cmpCount > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// read answers are sampled mid-cycle, away from the edge that launches them
	always @(negedge ref_clk)
		if (regRdValid === 1'b1)
		begin
			if (expQ.size() == 0)
				failCount++;
			else
			begin
				q = expQ.pop_front();
				chk(regRdData & q[15:8], q[7:0]);
			end
		end
	initial
	begin
		#200000;
		failCount++;
		finalReport();
	end
	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	initial
	begin
		tick(6);
		sys_rst = 1'b0;
		rd(8'h20, 8'hff, 8'h15);
		rd(8'h22, 8'hff, 8'hdd);
		rd(8'h21, 8'hff, 8'h01);
		rd(8'h30, 8'hff, 8'h00);
		repeat (4)
		begin
			d = $random(seed);
			host.xfer(1'b1, 8'h20, d);
			rd(8'h20, 8'hff, d);
			host.xfer(1'b1, 8'h22, d);
			rd(8'h22, 8'hff, d & 8'hdd);
			host.xfer(1'b1, 8'h21, d);
			rd(8'h21, 8'hff, {d[7:1], otpRegResetMask});
		end
		host.xfer(1'b1, 8'h20, 8'hff);
		host.xfer(1'b1, 8'h22, 8'hff);
		repeat (4)
		begin
			lv = $random(seed);
			tick(6);
			rd(8'h28, 8'h14, {3'b000, lv[0], 1'b0, lv[1], 2'b00});
			rd(8'h29, 8'h55, {1'b0, lv[4], 1'b0, lv[5], 1'b0, lv[6], 1'b0, lv[7]});
			rd(8'h2a, 8'h17, 8'h00);
			rd(8'h2b, 8'h55, 8'h00);
			chk({7'h00, irqOut}, 8'h00);
		end
		lv = 8'h00;
		for (int i = 0; i < 10; i++)
			for (int m = 1; m >= 0; m--)
			begin
				sel = m ? 8'h00 : 8'h01 << mBit[i];
				host.xfer(1'b1, 8'h20, i < 3 ? ~sel : 8'hff);
				host.xfer(1'b1, 8'h22, i > 3 ? ~sel : 8'hff);
				otpRegResetMask = !(i == 3 && m == 0);
				lv[inIdx[i]] = (i == 5 || i == 8);
				tick(8);
				host.xfer(1'b1, 8'h2a, 8'hff);
				host.xfer(1'b1, 8'h2b, 8'hff);
				tick(3);
				chk({7'h00, irqOut}, 8'h00);
				lv[inIdx[i]] = !(i == 5 || i == 8);
				tick(8);
				chk({7'h00, irqOut}, {7'h00, m == 0});
				rd(i < 4 ? 8'h2a : 8'h2b, 8'h01 << fBit[i], m ? 8'h00 : 8'h01 << fBit[i]);
				lv = 8'h00;
			end
		for (int k = 0; k < 20 && expQ.size() > 0; k++)
			tick(1);
		if (expQ.size() > 0)
			failCount++;
		finalReport();
	end
endmodule
